//--- inc/pic_pkg.sv
/*
  Shared constants and carrier types for the priority interrupt controller.
  Assumes a 32-bit APB with a 12-bit byte address and a single system clock.
*/
`default_nettype none
package pic_pkg;

  // ***************************************
  // Sizes
  // ***************************************
  localparam int NSRC = 128;
  localparam int NSW  = 8;
  localparam int PW   = 4;
  localparam int VW   = 9;
  localparam int AW   = 12;
  localparam int IW   = 7;

  // ***************************************
  // Register byte offsets
  // ***************************************
  localparam logic [AW-1:0] OFS_CPR      = 12'h000;
  localparam logic [AW-1:0] OFS_SWSET    = 12'h004;
  localparam logic [AW-1:0] OFS_STAT     = 12'h008;
  localparam logic [AW-1:0] OFS_MASK     = 12'h00c;
  localparam logic [AW-1:0] OFS_VEC      = 12'h010;
  localparam logic [AW-1:0] OFS_PRIO     = 12'h100;
  localparam logic [AW-1:0] OFS_PRIO_END = 12'h2fc;

  // ***************************************
  // Fields and reset values
  // ***************************************
  localparam int SW_CLR_LSB  = 8;
  localparam int VEC_IRQ_BIT = 16;
  localparam int EV_ACK      = 0;
  localparam int EV_NMI      = 1;
  localparam int EV_RAISE    = 2;
  localparam int NEV         = 3;
  localparam logic [PW-1:0]  CPR_RST  = 4'h0;
  localparam logic [PW-1:0]  PRIO_RST = 4'h0;
  localparam logic [NEV-1:0] MASK_RST = 3'h0;

  // ***************************************
  // Types
  // ***************************************
  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [31:0]   pwdata;
  } pic_apb_req_t;

  typedef struct packed {
    logic          irq;
    logic [VW-1:0] vector;
  } pic_core_req_t;

  typedef enum logic [1:0] {
    PIC_IDLE = 2'b01,
    PIC_HOLD = 2'b10
  } pic_state_t;

endpackage
`default_nettype wire

//--- src/pic_arbiter.sv
/*
  Combinational winner search over all pending sources.
  Assumes levels and pending bits come from registers on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module pic_arbiter #(
  parameter int N  = 128,
  parameter int PW = 4,
  parameter int IW = 7
) (
  // Requests
  input  wire logic [N-1:0]    i_pend,
  input  wire logic [N*PW-1:0] i_prio,
  // Winner
  output logic                 o_valid,
  output logic [IW-1:0]        o_idx,
  output logic [PW-1:0]        o_prio
);

  // Descending scan with >= so equal levels go to the lowest index
  always_comb begin
    o_valid = 1'b0;
    o_idx   = '0;
    o_prio  = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (i_pend[i] && (!o_valid || i_prio[i*PW +: PW] >= o_prio)) begin
        o_valid = 1'b1;
        o_idx   = IW'(i);
        o_prio  = i_prio[i*PW +: PW];
      end
    end
  end

endmodule
`default_nettype wire

//--- src/pic_top.sv
/*
  Priority interrupt controller: 128 sources, 16 levels, APB registers,
  held vectored request to the core, current-priority ceiling, NMI bypass.
  Assumes peripheral lines and the core acknowledge are on i_clk; the NMI
  pin is asynchronous.
*/
// Contract
// - accept 128 sources, each individually prioritised
// - distinct 9-bit vector per source
// - 16 levels, lowest index wins ties
// - software writes each source level
// - higher pending request preempts running routine
// - requests not above current priority withheld
// - eight software-raised sources join arbitration
// - NMI bypasses arbitration to core and io_processor
`timescale 1ns/1ns
`default_nettype none
module pic_top
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  // APB slave
  input  wire pic_pkg::pic_apb_req_t    i_apb,
  output logic [31:0]                   o_prdata,
  output logic                          o_pready,
  output logic                          o_pslverr,
  // Peripheral request lines, sources 8 and up
  input  wire logic [pic_pkg::NSRC-pic_pkg::NSW-1:0] i_src,
  // Core side
  input  wire logic                     i_ack,
  output var  pic_pkg::pic_core_req_t   o_core,
  output logic                          o_nmi_core,
  output logic                          o_nmi_io_processor,
  // Non-maskable pin and controller event interrupt
  input  wire logic                     i_nmi_pin,
  output logic                          o_int
);

  // ***************************************
  // Declarations
  // ***************************************
  logic [PW-1:0]    prio_q [NSRC];
  logic [NSRC*PW-1:0] prio_flat;
  logic [NSRC-1:0]  pend;
  logic [NSW-1:0]   sw_q;
  logic [PW-1:0]    cpr_q;
  logic [PW-1:0]    held_prio_q;
  logic [NEV-1:0]   stat_q;
  logic [NEV-1:0]   mask_q;
  logic [NEV-1:0]   ev;
  pic_state_t       state_q;
  logic             nmi_s1_q;
  logic             nmi_s2_q;
  logic             nmi_s3_q;
  logic             win_valid;
  logic [IW-1:0]    win_idx;
  logic [PW-1:0]    win_prio;
  logic             setup;
  logic             acc;
  logic             wr;
  logic             mapped;
  logic [31:0]      rd_data;
  logic [AW-1:0]    prio_off;
  logic [IW-1:0]    prio_idx;
  logic             in_prio;
  logic             take;
  logic             ack_take;

  // ***************************************
  // Pending vector and arbitration
  // ***************************************
  generate
    for (genvar g = 0; g < NSRC; g++) begin : g_src
      assign prio_flat[g*PW +: PW] = prio_q[g];
      if (g < NSW) begin : g_sw
        assign pend[g] = sw_q[g];
      end else begin : g_hw
        assign pend[g] = i_src[g-NSW];
      end
    end
  endgenerate

  pic_arbiter #(
    .N  (NSRC),
    .PW (PW),
    .IW (IW)
  ) u_arb (
    .i_pend  (pend),
    .i_prio  (prio_flat),
    .o_valid (win_valid),
    .o_idx   (win_idx),
    .o_prio  (win_prio)
  );

  // Only a level strictly above the current priority is presented
  assign take     = (state_q == PIC_IDLE) && win_valid && (win_prio > cpr_q);
  assign ack_take = (state_q == PIC_HOLD) && i_ack;

  // ***************************************
  // Core request hold and acknowledge
  // ***************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q     <= PIC_IDLE;
      o_core      <= '0;
      held_prio_q <= CPR_RST;
    end else begin
      case (state_q)
        PIC_IDLE: begin
          if (take) begin
            state_q       <= PIC_HOLD;
            o_core.irq    <= 1'b1;
            o_core.vector <= VW'(win_idx);
            held_prio_q   <= win_prio;
          end
        end
        PIC_HOLD: begin
          if (i_ack) begin
            state_q    <= PIC_IDLE;
            o_core.irq <= 1'b0;
          end
        end
        default: begin
          state_q    <= PIC_IDLE;
          o_core.irq <= 1'b0;
        end
      endcase
    end
  end

  // ***************************************
  // APB slave
  // ***************************************
  assign setup    = i_apb.psel && !i_apb.penable;
  assign acc      = i_apb.psel && i_apb.penable && o_pready;
  assign wr       = acc && i_apb.pwrite && !o_pslverr;
  assign prio_off = i_apb.paddr - OFS_PRIO;
  assign prio_idx = prio_off[IW+1:2];
  assign in_prio  = (i_apb.paddr >= OFS_PRIO) && (i_apb.paddr <= OFS_PRIO_END);

  always_comb begin
    mapped  = i_apb.paddr[1:0] == 2'h0;
    rd_data = 32'h0;
    if (in_prio) begin
      rd_data[PW-1:0] = prio_q[prio_idx];
    end else begin
      case (i_apb.paddr)
        OFS_CPR:   rd_data[PW-1:0]  = cpr_q;
        OFS_SWSET: rd_data[NSW-1:0] = sw_q;
        OFS_STAT:  rd_data[NEV-1:0] = stat_q;
        OFS_MASK:  rd_data[NEV-1:0] = mask_q;
        OFS_VEC: begin
          rd_data[VW-1:0]      = o_core.vector;
          rd_data[VEC_IRQ_BIT] = o_core.irq;
        end
        default:   mapped = 1'b0;
      endcase
    end
  end

  // One wait-free access phase: answer prepared in the setup cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && !mapped;
      o_prdata  <= (setup && mapped && !i_apb.pwrite) ? rd_data : 32'h0;
    end
  end

  // ***************************************
  // Priority levels
  // ***************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NSRC; i++) begin
        prio_q[i] <= PRIO_RST;
      end
    end else if (wr && in_prio) begin
      prio_q[prio_idx] <= i_apb.pwdata[PW-1:0];
    end
  end

  // ***************************************
  // Current priority
  // ***************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cpr_q <= CPR_RST;
    end else if (ack_take) begin
      cpr_q <= held_prio_q;
    end else if (wr && i_apb.paddr == OFS_CPR) begin
      cpr_q <= i_apb.pwdata[PW-1:0];
    end
  end

  // ***************************************
  // Software sources
  // ***************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sw_q <= '0;
    end else if (wr && i_apb.paddr == OFS_SWSET) begin
      sw_q <= (sw_q | i_apb.pwdata[NSW-1:0]) & ~i_apb.pwdata[SW_CLR_LSB +: NSW];
    end
  end

  // ***************************************
  // Non-maskable path
  // ***************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      nmi_s1_q   <= 1'b0;
      nmi_s2_q   <= 1'b0;
      nmi_s3_q   <= 1'b0;
      o_nmi_core <= 1'b0;
      o_nmi_io_processor <= 1'b0;
    end else begin
      nmi_s1_q   <= i_nmi_pin;
      nmi_s2_q   <= nmi_s1_q;
      nmi_s3_q   <= nmi_s2_q;
      o_nmi_core <= nmi_s2_q;
      o_nmi_io_processor <= nmi_s2_q;
    end
  end

  // ***************************************
  // Event status, mask and interrupt
  // ***************************************
  always_comb begin
    ev           = '0;
    ev[EV_ACK]   = ack_take;
    ev[EV_NMI]   = nmi_s2_q && !nmi_s3_q;
    ev[EV_RAISE] = take;
  end

  // A new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_q <= '0;
    end else if (wr && i_apb.paddr == OFS_STAT) begin
      stat_q <= (stat_q & ~i_apb.pwdata[NEV-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mask_q <= MASK_RST;
    end else if (wr && i_apb.paddr == OFS_MASK) begin
      mask_q <= i_apb.pwdata[NEV-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_int <= 1'b0;
    end else begin
      o_int <= |(stat_q & mask_q);
    end
  end

  // ***************************************
  // Assertions
  // ***************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_sw_raise;
    wr && i_apb.paddr == OFS_SWSET && i_apb.pwdata[0] && !i_apb.pwdata[SW_CLR_LSB];
  endsequence

  sequence s_prio_write;
    wr && in_prio;
  endsequence

  sequence s_presented;
    $rose(o_core.irq);
  endsequence

  AST_WITHHOLD: assert property (
    s_presented |-> $past(win_prio) > $past(cpr_q))
    else $error("request presented at or below current priority");

  AST_VECTOR: assert property (
    s_presented |-> o_core.vector == {2'b00, $past(win_idx)})
    else $error("vector does not match winning source");

  AST_HOLD: assert property (
    o_core.irq && !i_ack |=> o_core.irq && $stable(o_core.vector))
    else $error("request dropped or vector changed before acknowledge");

  AST_ACK_CPR: assert property (
    o_core.irq && i_ack |=> !o_core.irq && cpr_q == $past(held_prio_q))
    else $error("acknowledge did not raise current priority");

  AST_PREEMPT: assert property (
    state_q == PIC_IDLE && win_valid && win_prio > cpr_q |=> o_core.irq)
    else $error("higher pending request not signalled");

  AST_WINNER: assert property (
    win_valid |-> pend[win_idx] && prio_q[win_idx] == win_prio)
    else $error("winner is not a pending source at its level");

  AST_PRIO_WR: assert property (
    s_prio_write |=> prio_q[$past(prio_idx)] == $past(i_apb.pwdata[PW-1:0]))
    else $error("level write not stored");

  AST_SW_SRC: assert property (
    s_sw_raise |=> sw_q[0] && pend[0])
    else $error("software source not raised");

  AST_NMI: assert property (
    $rose(nmi_s2_q) |=> o_nmi_core && o_nmi_io_processor)
    else $error("non-maskable request not forwarded");

  AST_HW_SRC: assert property (
    pend[NSRC-1] == i_src[NSRC-NSW-1])
    else $error("peripheral line not pending");

endmodule
`default_nettype wire

//--- tb/pic_core_model.sv
/*
  Core-side partner: acknowledges a held request after a chosen delay,
  only while the bench enables it.
  Assumes request, enable and delay come from i_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module pic_core_model (
  // Clock and request
  input  wire logic       i_clk,
  input  wire logic       i_irq,
  input  wire logic       i_en,
  input  wire logic [2:0] i_dly,
  // Acknowledge
  output logic            o_ack
);
  logic [2:0] cnt_q;
  // ******
  // Ack pulse, only while a request stands
  // ******
  always_ff @(posedge i_clk) begin
    o_ack <= 1'b0;
    if (!i_irq || !i_en || o_ack) begin
      cnt_q <= 3'h0;
    end else if (cnt_q == i_dly) begin
      o_ack <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
/*
  Self-checking bench for the priority interrupt controller.
  Assumes zero-wait APB and the core partner model beside the design.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import pic_pkg::*;
;
  logic          i_clk, i_rst, ack, nmi, int_w, pready, slverr, nmi_c, nmi_i, err_v, ack_en;
  logic [2:0]    dly_q;
  logic [119:0]  src_q;
  logic [31:0]   prdata, seed, rdv;
  pic_apb_req_t  apb_q;
  pic_core_req_t core;
  int            error_cnt, checks, lvl[NSRC], cpr_m, s, l;
  int            cyc = 0;
  bit [NSRC-1:0] pend_m;
  logic [AW-1:0] regs[7] = '{OFS_CPR, OFS_SWSET, OFS_STAT, OFS_MASK, OFS_VEC, OFS_PRIO,
                             OFS_PRIO_END};

  pic_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_apb(apb_q), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(slverr), .i_src(src_q), .i_ack(ack), .o_core(core),
    .o_nmi_core(nmi_c), .o_nmi_io_processor(nmi_i), .i_nmi_pin(nmi), .o_int(int_w));
  pic_core_model core_m (.i_clk(i_clk), .i_irq(core.irq), .i_en(ack_en), .i_dly(dly_q),
    .o_ack(ack));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end

  // ******
  // Helpers
  // ******
  task automatic conclude();
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(logic w, logic [AW-1:0] a, logic [31:0] d);
    @(posedge i_clk);
    apb_q <= {1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    apb_q.penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rdv = prdata;
    err_v = slverr;
    apb_q <= '0;
  endtask

  task automatic rd(logic [AW-1:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Model winner: strictly above ceiling, lowest index on ties
  function automatic int win();
    int w = -1;
    int b = cpr_m;
    for (int i = 0; i < NSRC; i++) begin
      if (pend_m[i] && lvl[i] > b) begin
        w = i;
        b = lvl[i];
      end
    end
    return w;
  endfunction

  task automatic setlvl(int n, int v);
    lvl[n] = v;
    pend_m[n] = 1'b1;
    apb(1'b1, OFS_PRIO + AW'(4 * n), 32'(v));
  endtask

  task automatic serve();
    int w;
    w = win();
    while (w >= 0) begin
      for (int t = 0; t < 40 && core.irq !== 1'b1; t++) @(posedge i_clk);
      chk(core, {1'b1, 9'(w)});
      rd(OFS_VEC, 32'h10000 | 32'(w));
      dly_q <= 3'(xs());
      ack_en <= 1'b1;
      while (core.irq === 1'b1) begin
        chk(core, {1'b1, 9'(w)});
        @(posedge i_clk);
      end
      // Hold off the next acknowledge until the ceiling has been read back
      ack_en <= 1'b0;
      cpr_m = lvl[w];
      rd(OFS_CPR, 32'(cpr_m));
      w = win();
    end
    repeat (8) begin
      @(posedge i_clk);
      chk(core.irq, 1'b0);
    end
  endtask

  // ******
  // Main sequence
  // ******
  initial begin
    i_rst = 1'b1;
    apb_q = '0;
    src_q = '0;
    nmi = 1'b0;
    dly_q = 3'h0;
    ack_en = 1'b0;
    seed = 32'h31;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (regs[i]) rd(regs[i], 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(err_v, 1'b1);
    chk(rdv, 32'h0);
    apb(1'b1, 12'h001, 32'h1);
    chk(err_v, 1'b1);
    for (int r = 0; r < 6; r++) begin
      apb(1'b1, OFS_CPR, 32'hf);
      for (int k = 0; k < 3; k++) begin
        s = (r == 0 && k < 2) ? (k == 0 ? 127 : 8) : 8 + int'(xs() % 120);
        l = (k == 2) ? int'(xs() % 16) : 1 + int'(xs() % 15);
        setlvl(s, (r == 0 && k < 2) ? 12 : l);
      end
      s = (r == 0) ? 0 : int'(xs() % 8);
      setlvl(s, 1 + int'(xs() % 15));
      apb(1'b1, OFS_SWSET, 32'h1 << s);
      src_q <= pend_m[127:8];
      rd(OFS_SWSET, 32'(pend_m[7:0]));
      apb(1'b1, OFS_CPR, 32'h0);
      cpr_m = 0;
      serve();
      src_q <= '0;
      pend_m = '0;
      apb(1'b1, OFS_SWSET, 32'hff00);
      apb(1'b1, OFS_CPR, 32'h0);
      cpr_m = 0;
    end
    rd(OFS_STAT, 32'h5);
    apb(1'b1, OFS_MASK, 32'h4);
    repeat (2) @(posedge i_clk);
    chk(int_w, 1'b1);
    apb(1'b1, OFS_STAT, 32'h7);
    repeat (2) @(posedge i_clk);
    chk(int_w, 1'b0);
    rd(OFS_STAT, 32'h0);
    @(posedge i_clk);
    nmi <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(nmi_c, 1'b0);
    @(posedge i_clk);
    chk({nmi_c, nmi_i}, 2'b11);
    apb(1'b1, OFS_MASK, 32'h2);
    repeat (2) @(posedge i_clk);
    chk(int_w, 1'b1);
    rd(OFS_MASK, 32'h2);
    nmi <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk({nmi_c, nmi_i, core.irq}, 3'b000);
    conclude();
  end
endmodule
`default_nettype wire
